// ===== hdl/uart_fifo_control_bits.sv
`timescale 1ns/1ps
module uart_fifo_control_bits
  import fifo_ctl_pkg::*;
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  output logic TXD,
  input wire logic RXD,
  input wire logic CTS_N,
  output logic RTS
);
  logic [10:0] ctrl_reg, ctrl_next;
  logic [ST_W-1:0] status_reg, status_next, mask_reg, mask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic rts_reg, rts_next;
  logic rxd_s1_reg, rxd_s2_reg, cts_s1_reg, cts_s2_reg;
  logic acc_wr, acc_rd, addr_ok;
  logic rd_wait_reg, rd_wait_next;
  logic tx_wr, tx_rd, rx_wr, rx_rd, tx_clr, rx_clr;
  logic [7:0] tx_q, rx_q, rx_byte;
  logic [CW-1:0] tx_cnt, rx_cnt;
  logic tx_busy, eng_txd, rx_valid, serial_in, cts_ok, tx_empty_flag, rx_level_hit;
  logic loop_en, hs_en;
  logic [1:0] tx_fifo_trigger_level;
  logic [2:0] rts_trigger_level;
  typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_LOAD} tx_state_type;
  tx_state_type tx_state_reg, tx_state_next;

  assign loop_en = ctrl_reg[LOOP_BIT];
  assign hs_en = ctrl_reg[MCE_BIT];
  assign tx_fifo_trigger_level = ctrl_reg[TX_FIFO_TRIGGER_LEVEL_LO +: 2];
  assign rts_trigger_level = ctrl_reg[RTS_TRIGGER_LEVEL_LO +: 3];

  // Writes complete in their first access cycle. Reads insert one wait state, in which
  // the read data register is loaded, so PRDATA stands from a flip-flop when PREADY rises.
  assign acc_wr = PSEL && PENABLE && PWRITE;
  assign acc_rd = PSEL && PENABLE && !PWRITE && !rd_wait_reg;
  assign PREADY = PWRITE || rd_wait_reg;

  always_comb begin
    rd_wait_next = PSEL && PENABLE && !PWRITE && !rd_wait_reg;
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      rd_wait_reg <= 1'b0;
    end else begin
      rd_wait_reg <= rd_wait_next;
    end
  end

  always_comb begin
    case (PADDR)
      OFS_CTRL, OFS_COUNT, OFS_STATUS, OFS_MASK, OFS_TXDATA, OFS_RXDATA: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL && PENABLE && PREADY && !addr_ok;

  always_ff @(posedge MCLK) begin
    rxd_s1_reg <= RXD;
    rxd_s2_reg <= rxd_s1_reg;
    cts_s1_reg <= CTS_N;
    cts_s2_reg <= cts_s1_reg;
  end

  // Clears act from the write edge and persist while the bit stays set.
  assign tx_clr = SRST || ctrl_reg[TXCLR_BIT];
  assign rx_clr = SRST || ctrl_reg[RXCLR_BIT];
  assign tx_wr = acc_wr && (PADDR == OFS_TXDATA);
  assign rx_rd = acc_rd && (PADDR == OFS_RXDATA);
  assign rx_wr = rx_valid;

  byte_fifo u_tx_fifo (
    .clk(MCLK),
    .clr(tx_clr),
    .wr_en(tx_wr),
    .wr_data(PWDATA[7:0]),
    .rd_en(tx_rd),
    .rd_data(tx_q),
    .count(tx_cnt)
  );

  byte_fifo u_rx_fifo (
    .clk(MCLK),
    .clr(rx_clr),
    .wr_en(rx_wr),
    .wr_data(rx_byte),
    .rd_en(rx_rd),
    .rd_data(rx_q),
    .count(rx_cnt)
  );

  assign cts_ok = hs_en ? !cts_s2_reg : 1'b1;
  assign serial_in = loop_en ? eng_txd : rxd_s2_reg;
  assign TXD = eng_txd;

  // The FIFO read data lags its pointer by one cycle, hence the fetch state.
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_rd = 1'b0;
    case (tx_state_reg)
      TX_IDLE: begin
        if (!tx_busy && cts_ok && tx_cnt != '0 && !tx_clr) begin
          tx_state_next = TX_FETCH;
        end
      end
      TX_FETCH: begin
        tx_state_next = TX_LOAD;
      end
      TX_LOAD: begin
        tx_rd = !tx_clr;
        tx_state_next = TX_IDLE;
      end
      default: tx_state_next = TX_IDLE;
    endcase
  end

  serial_bit_engine u_engine (
    .clk(MCLK),
    .rst(SRST),
    .tx_start(tx_rd),
    .tx_byte(tx_q),
    .tx_busy(tx_busy),
    .txd(eng_txd),
    .rxd(serial_in),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte)
  );

  assign tx_empty_flag = tx_cnt <= tx_level(tx_fifo_trigger_level);
  assign rx_level_hit = rx_cnt >= rts_level(rts_trigger_level);

  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    rts_next = hs_en && rx_level_hit;
    prdata_next = prdata_reg;
    if (acc_wr && PADDR == OFS_CTRL) begin
      ctrl_next = PWDATA[10:0] & CTRL_MASK;
    end
    if (acc_wr && PADDR == OFS_MASK) begin
      mask_next = PWDATA[ST_W-1:0];
    end
    // Set wins over a write-one-to-clear in the same cycle.
    status_next = status_reg;
    if (acc_wr && PADDR == OFS_STATUS) begin
      status_next = status_reg & ~PWDATA[ST_W-1:0];
    end
    if (tx_empty_flag) begin
      status_next[ST_TXE] = 1'b1;
    end
    if (rx_valid) begin
      status_next[ST_RXD] = 1'b1;
    end
    if (acc_rd) begin
      case (PADDR)
        OFS_CTRL: prdata_next = {21'h0, ctrl_reg};
        OFS_COUNT: prdata_next = {17'h0, tx_cnt, 1'b0, rx_cnt};
        OFS_STATUS: prdata_next = {30'h0, status_reg};
        OFS_MASK: prdata_next = {30'h0, mask_reg};
        OFS_RXDATA: prdata_next = {24'h0, rx_q};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= '0;
      status_reg <= '0;
      rts_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      tx_state_reg <= TX_IDLE;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      status_reg <= status_next;
      rts_reg <= rts_next;
      prdata_reg <= prdata_next;
      tx_state_reg <= tx_state_next;
    end
  end

  // Read data are loaded in the wait cycle and stand while PREADY is high.
  assign PRDATA = prdata_reg;
  assign RTS = rts_reg;
  assign IRQ = |(status_reg & mask_reg);

  // Checks on the handshake lines.
  AST_RTS_OFF: assert property (@(posedge MCLK) disable iff (SRST)
    !hs_en |=> !RTS) else $error("RTS high with handshake off");

  AST_RTS_LEVEL: assert property (@(posedge MCLK) disable iff (SRST)
    $past(hs_en) && $past(rx_cnt) >= rts_level($past(rts_trigger_level)) |-> RTS)
    else $error("RTS missed level");

  AST_RTS_BELOW: assert property (@(posedge MCLK) disable iff (SRST)
    $past(rx_cnt) < rts_level($past(rts_trigger_level)) |-> !RTS)
    else $error("RTS high below level");

  // A transmit start needs a clear CTS while the handshake is enabled.
  AST_CTS_GATE: assert property (@(posedge MCLK) disable iff (SRST)
    hs_en && cts_s2_reg && tx_state_reg == TX_IDLE |=> tx_state_reg == TX_IDLE)
    else $error("start without CTS");

  // With the handshake off the pin level must not hold back a start.
  AST_CTS_IGNORED: assert property (@(posedge MCLK) disable iff (SRST)
    !hs_en && tx_state_reg == TX_IDLE && !tx_busy && tx_cnt != '0 && !tx_clr
    |=> tx_state_reg == TX_FETCH) else $error("start held without handshake");

  // Checks on the transmit-empty flag and trigger field.
  AST_TXE_SET: assert property (@(posedge MCLK) disable iff (SRST)
    tx_cnt <= tx_level(tx_fifo_trigger_level) |=> status_reg[ST_TXE])
    else $error("empty flag not set");

  AST_TXE_CLEAR: assert property (@(posedge MCLK) disable iff (SRST)
    acc_wr && PADDR == OFS_STATUS && PWDATA[ST_TXE] && tx_cnt > tx_level(tx_fifo_trigger_level)
    |=> !status_reg[ST_TXE]) else $error("empty flag not cleared");

  AST_TRIG_FIELD: assert property (@(posedge MCLK) disable iff (SRST)
    acc_wr && PADDR == OFS_CTRL |=> tx_fifo_trigger_level == $past(PWDATA[TX_FIFO_TRIGGER_LEVEL_LO +: 2]))
    else $error("trigger field not written");

  AST_TRIG_RESET: assert property (@(posedge MCLK)
    SRST |=> tx_fifo_trigger_level == 2'h0) else $error("trigger reset wrong");

  // Checks on the FIFO clears.
  AST_TX_CLEAR: assert property (@(posedge MCLK) disable iff (SRST)
    acc_wr && PADDR == OFS_CTRL && PWDATA[TXCLR_BIT] |=> ##1 tx_cnt == 0)
    else $error("tx fifo not cleared");

  AST_TX_CLR_EMPTY: assert property (@(posedge MCLK) disable iff (SRST)
    tx_clr |=> tx_cnt == 0) else $error("tx clear left data");

  AST_RX_CLEAR: assert property (@(posedge MCLK) disable iff (SRST)
    acc_wr && PADDR == OFS_CTRL && PWDATA[RXCLR_BIT] |=> ##1 rx_cnt == 0)
    else $error("rx fifo not cleared");

  AST_RX_CLR_EMPTY: assert property (@(posedge MCLK) disable iff (SRST)
    rx_clr |=> rx_cnt == 0) else $error("rx clear left data");

  AST_RESET_EMPTY: assert property (@(posedge MCLK)
    SRST |=> tx_cnt == 0 && rx_cnt == 0) else $error("reset left data");

  AST_HOLD_CLEAR: assert property (@(posedge MCLK) disable iff (SRST)
    ctrl_reg[TXCLR_BIT] && $past(ctrl_reg[TXCLR_BIT]) |-> tx_cnt == 0)
    else $error("held clear let data in");

  AST_RX_HOLD_CLEAR: assert property (@(posedge MCLK) disable iff (SRST)
    ctrl_reg[RXCLR_BIT] && $past(ctrl_reg[RXCLR_BIT]) |-> rx_cnt == 0)
    else $error("held rx clear let data in");

  // Checks on the receiver input selection.
  AST_LOOP: assert property (@(posedge MCLK) disable iff (SRST)
    loop_en |-> serial_in == TXD) else $error("loopback not routed");

  AST_LOOP_OFF: assert property (@(posedge MCLK) disable iff (SRST)
    !loop_en |-> serial_in == rxd_s2_reg) else $error("receiver not on pin");

  // Checks on the transmit FIFO size.
  AST_DEPTH: assert property (@(posedge MCLK) disable iff (SRST)
    tx_cnt <= CW'(DEPTH)) else $error("tx count above depth");

  AST_FULL_HOLD: assert property (@(posedge MCLK) disable iff (SRST)
    tx_cnt == CW'(DEPTH) && !tx_rd && !tx_clr |=> tx_cnt == CW'(DEPTH))
    else $error("full tx fifo changed count");
endmodule

// ===== hdl/fifo_ctl_pkg.sv
package fifo_ctl_pkg;
  localparam int DEPTH = 64;
  localparam int AW = 6;
  localparam int CW = 7;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_COUNT = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_MASK = 12'h00C;
  localparam logic [11:0] OFS_TXDATA = 12'h010;
  localparam logic [11:0] OFS_RXDATA = 12'h014;
  localparam int LOOP_BIT = 0;
  localparam int RXCLR_BIT = 1;
  localparam int TXCLR_BIT = 2;
  localparam int MCE_BIT = 3;
  localparam int TX_FIFO_TRIGGER_LEVEL_LO = 4;
  localparam int RTS_TRIGGER_LEVEL_LO = 8;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [10:0] CTRL_MASK = 11'h73F;
  localparam int ST_TXE = 0;
  localparam int ST_RXD = 1;
  localparam int ST_W = 2;
  localparam int CNT_RX_LO = 0;
  localparam int CNT_TX_LO = 8;
  localparam int BIT_DIV = 16;
  localparam int BIT_CW = 4;
  localparam int FRAME_BITS = 10;

  function automatic logic [CW-1:0] tx_level(input logic [1:0] enc);
    case (enc)
      2'h0: tx_level = 7'd32;
      2'h1: tx_level = 7'd16;
      2'h2: tx_level = 7'd2;
      default: tx_level = 7'd0;
    endcase
  endfunction

  function automatic logic [CW-1:0] rts_level(input logic [2:0] enc);
    case (enc)
      3'h0: rts_level = 7'd63;
      3'h1: rts_level = 7'd1;
      3'h2: rts_level = 7'd8;
      3'h3: rts_level = 7'd16;
      3'h4: rts_level = 7'd32;
      3'h5: rts_level = 7'd48;
      3'h6: rts_level = 7'd54;
      default: rts_level = 7'd60;
    endcase
  endfunction
endpackage

// ===== hdl/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo
  import fifo_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic clr,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic [CW-1:0] count
);
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [7:0] rd_reg;
  logic do_wr, do_rd;

  // Writes to a full FIFO and reads of an empty one are dropped.
  always_comb begin
    do_wr = wr_en && (cnt_reg != CW'(DEPTH));
    do_rd = rd_en && (cnt_reg != '0);
    wp_next = wp_reg + AW'(do_wr);
    rp_next = rp_reg + AW'(do_rd);
    cnt_next = cnt_reg + CW'(do_wr) - CW'(do_rd);
    if (clr) begin
      wp_next = '0;
      rp_next = '0;
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    wp_reg <= wp_next;
    rp_reg <= rp_next;
    cnt_reg <= cnt_next;
    if (do_wr) begin
      mem[wp_reg] <= wr_data;
    end
    rd_reg <= mem[rp_reg];
  end

  assign rd_data = rd_reg;
  assign count = cnt_reg;
endmodule

// ===== hdl/serial_bit_engine.sv
`timescale 1ns/1ps
module serial_bit_engine
  import fifo_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_start,
  input wire logic [7:0] tx_byte,
  output logic tx_busy,
  output logic txd,
  input wire logic rxd,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  logic [BIT_CW-1:0] tdiv_reg, tdiv_next, rdiv_reg, rdiv_next;
  logic [3:0] tbit_reg, tbit_next, rbit_reg, rbit_next;
  logic [9:0] tsh_reg, tsh_next;
  logic [8:0] rsh_reg, rsh_next;
  logic tbusy_reg, tbusy_next, rbusy_reg, rbusy_next, rv_reg, rv_next;

  // Plain 8N1 framing; receive samples at mid bit after seeing the start edge.
  always_comb begin
    tdiv_next = tdiv_reg;
    tbit_next = tbit_reg;
    tsh_next = tsh_reg;
    tbusy_next = tbusy_reg;
    if (!tbusy_reg) begin
      if (tx_start) begin
        tsh_next = {1'b1, tx_byte, 1'b0};
        tbusy_next = 1'b1;
        tdiv_next = '0;
        tbit_next = '0;
      end
    end else if (tdiv_reg == BIT_CW'(BIT_DIV - 1)) begin
      tdiv_next = '0;
      tsh_next = {1'b1, tsh_reg[9:1]};
      tbit_next = tbit_reg + 4'd1;
      if (tbit_reg == 4'(FRAME_BITS - 1)) begin
        tbusy_next = 1'b0;
      end
    end else begin
      tdiv_next = tdiv_reg + BIT_CW'(1);
    end
    rdiv_next = rdiv_reg;
    rbit_next = rbit_reg;
    rsh_next = rsh_reg;
    rbusy_next = rbusy_reg;
    rv_next = 1'b0;
    if (!rbusy_reg) begin
      if (!rxd) begin
        rbusy_next = 1'b1;
        rdiv_next = BIT_CW'(BIT_DIV / 2);
        rbit_next = '0;
      end
    end else if (rdiv_reg == BIT_CW'(BIT_DIV - 1)) begin
      rdiv_next = '0;
      rsh_next = {rxd, rsh_reg[8:1]};
      rbit_next = rbit_reg + 4'd1;
      if (rbit_reg == 4'(FRAME_BITS - 1)) begin
        rbusy_next = 1'b0;
        rv_next = rxd;
      end
    end else begin
      rdiv_next = rdiv_reg + BIT_CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tdiv_reg <= '0;
      tbit_reg <= '0;
      tsh_reg <= 10'h3FF;
      tbusy_reg <= 1'b0;
      rdiv_reg <= '0;
      rbit_reg <= '0;
      rsh_reg <= '0;
      rbusy_reg <= 1'b0;
      rv_reg <= 1'b0;
    end else begin
      tdiv_reg <= tdiv_next;
      tbit_reg <= tbit_next;
      tsh_reg <= tsh_next;
      tbusy_reg <= tbusy_next;
      rdiv_reg <= rdiv_next;
      rbit_reg <= rbit_next;
      rsh_reg <= rsh_next;
      rbusy_reg <= rbusy_next;
      rv_reg <= rv_next;
    end
  end

  assign tx_busy = tbusy_reg;
  assign txd = tsh_reg[0];
  assign rx_valid = rv_reg;
  // After the stop sample the start bit has left the nine-bit shifter: data sit in 7:0.
  assign rx_byte = rsh_reg[7:0];
endmodule

// ===== verification/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
  input wire logic clk,
  input wire logic txd,
  input wire logic hold_off,
  output logic rxd,
  output logic cts_n,
  output logic [7:0] last_byte,
  output int got
);
  logic [7:0] shift_reg;

  // While held off the peer refuses data, so CTS_N stays high.
  assign cts_n = hold_off;

  initial begin
    rxd = 1'b1;
    last_byte = 8'h00;
    got = 0;
  end

  // Sampling at mid-bit: 24 clocks after the start edge, then every 16 clocks.
  initial begin
    forever begin
      @(negedge txd);
      repeat (24) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        shift_reg[i] = txd;
        repeat (16) @(posedge clk);
      end
      last_byte = shift_reg;
      got = got + 1;
    end
  end

  task automatic send(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= frame[i];
      repeat (16) @(posedge clk);
    end
  endtask
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import fifo_ctl_pkg::*;
  localparam logic [31:0] LOOP_V = 32'h0000_0001;
  localparam logic [31:0] RXC_V = 32'h0000_0002;
  localparam logic [31:0] TXC_V = 32'h0000_0004;
  localparam logic [31:0] MCE_V = 32'h0000_0008;
  logic mclk, srst, psel, penable, pwrite, hold_off;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, irq, txd, rxd, cts_n, rts, err;
  logic [7:0] last_byte;
  int got;
  int fails = 0;
  int samples_checked = 0;
  int lvl[4] = '{32, 16, 2, 0};

  uart_fifo_control_bits i_dut (.MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .TXD(txd), .RXD(rxd), .CTS_N(cts_n), .RTS(rts));
  serial_peer i_peer (.clk(mclk), .txd(txd), .hold_off(hold_off), .rxd(rxd), .cts_n(cts_n),
    .last_byte(last_byte), .got(got));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      fails++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // Response and read data are taken at the edge where PREADY is seen high; the extra
  // edge after release lets register updates settle before the caller looks at pins.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, want);
  endtask

  task automatic wait_rx(input int n);
    for (int i = 0; i < 200; i++) begin
      apb(1'b0, OFS_COUNT, 32'h0000_0000);
      if (rd[6:0] == n[6:0]) break;
    end
  endtask

  task automatic t_trigger;
    hold_off = 1'b1;
    for (int e = 0; e < 4; e++) begin
      wr(OFS_CTRL, MCE_V | TXC_V | (32'(e) << TX_FIFO_TRIGGER_LEVEL_LO));
      wr(OFS_CTRL, MCE_V | (32'(e) << TX_FIFO_TRIGGER_LEVEL_LO));
      rdc(OFS_CTRL, MCE_V | (32'(e) << TX_FIFO_TRIGGER_LEVEL_LO));
      for (int n = 0; n < lvl[e]; n++) wr(OFS_TXDATA, 32'(n));
      wr(OFS_STATUS, 32'h0000_0001);
      rdc(OFS_STATUS, 32'h0000_0001);
      wr(OFS_TXDATA, 32'h0000_0055);
      wr(OFS_STATUS, 32'h0000_0001);
      rdc(OFS_STATUS, 32'h0000_0000);
      rdc(OFS_COUNT, 32'(lvl[e] + 1) << CNT_TX_LO);
    end
    for (int n = 0; n < 64; n++) wr(OFS_TXDATA, 32'(n));
    rdc(OFS_COUNT, 32'(DEPTH) << CNT_TX_LO);
    wr(OFS_CTRL, MCE_V | TXC_V);
    wr(OFS_TXDATA, 32'h0000_0011);
    rdc(OFS_COUNT, 32'h0000_0000);
    wr(OFS_CTRL, MCE_V);
  endtask

  task automatic t_cts;
    wr(OFS_TXDATA, 32'h0000_00A5);
    repeat (300) @(posedge mclk);
    rdc(OFS_COUNT, 32'h0000_0100);
    hold_off = 1'b0;
    for (int i = 0; i < 2000 && got < 1; i++) @(posedge mclk);
    chk(32'(last_byte), 32'h0000_00A5);
    hold_off = 1'b1;
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_TXDATA, 32'h0000_003C);
    for (int i = 0; i < 2000 && got < 2; i++) @(posedge mclk);
    chk(32'(last_byte), 32'h0000_003C);
    chk(32'(rts), 32'h0000_0000);
  endtask

  task automatic t_loop;
    wr(OFS_CTRL, LOOP_V);
    wr(OFS_STATUS, 32'h0000_0003);
    wr(OFS_MASK, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0000);
    wr(OFS_TXDATA, 32'h0000_0096);
    wr(OFS_TXDATA, 32'h0000_005A);
    wait_rx(2);
    rdc(OFS_COUNT, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0001);
    wr(OFS_MASK, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    wr(OFS_MASK, 32'h0000_0002);
    wr(OFS_STATUS, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0000);
    rdc(OFS_RXDATA, 32'h0000_0096);
    wr(OFS_CTRL, LOOP_V | RXC_V);
    rdc(OFS_COUNT, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0000);
  endtask

  task automatic t_rts;
    wr(OFS_CTRL, MCE_V | (32'h0000_0002 << RTS_TRIGGER_LEVEL_LO));
    for (int i = 0; i < 8; i++) begin
      chk(32'(rts), 32'h0000_0000);
      i_peer.send(8'(i));
      wait_rx(i + 1);
    end
    chk(32'(rts), 32'h0000_0001);
    wr(OFS_CTRL, MCE_V | RXC_V);
    repeat (3) @(posedge mclk);
    chk(32'(rts), 32'h0000_0000);
  endtask

  task automatic t_misc;
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    wr(OFS_CTRL, MCE_V | (32'h0000_0003 << TX_FIFO_TRIGGER_LEVEL_LO));
    wr(OFS_TXDATA, 32'h0000_0001);
    wr(OFS_TXDATA, 32'h0000_0002);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rdc(OFS_COUNT, 32'h0000_0000);
    rdc(OFS_CTRL, 32'h0000_0000);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    end_of_test();
  end

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    hold_off = 1'b0;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    rdc(OFS_CTRL, 32'h0000_0000);
    rdc(OFS_COUNT, 32'h0000_0000);
    chk(32'(rts), 32'h0000_0000);
    $display("test reset done");
    t_trigger();
    $display("test trigger done");
    t_cts();
    $display("test handshake done");
    t_loop();
    $display("test loopback done");
    t_rts();
    $display("test rts done");
    t_misc();
    $display("test misc done");
    end_of_test();
  end
endmodule
